// ===== ebcs_pkg.sv
/*
 * Shared constants for the external bus cycle sequencer: register indices,
 * field positions, reset values, cycle counts, transfer sizes and states.
 * Assumes a 32-bit APB register bus and eight chip-selects, boot select last.
 */
package ebcs_pkg;

	// register indices; byte address is four times the index
	localparam logic [31:0] SC_IDX = 32'hFFFF8000;
	localparam logic [31:0] PW_IDX = 32'hFFFFA811;
	localparam logic [31:0] TM_IDX = 32'hFFFFA820;
	localparam logic [31:0] ST_IDX = 32'hFFFFA821;
	localparam int DEC_W = 12;

	// system_control fields
	localparam int SC_TIMEOUT_SHORT_CYCLE = 15;
	localparam int SC_BPE = 14;
	localparam int SC_INV = 13;
	localparam int SC_CPU_STANDBY = 12;
	localparam int SC_PERIPH_DIVIDER_BIT3 = 11;
	localparam int SC_PERIPH_DIVIDER_BIT1 = 7;
	localparam int SC_PERIPH_DIVIDER_BIT0 = 6;
	localparam int SC_FAST = 3;
	localparam int SC_IDLE = 1;
	localparam logic [15:0] SC_RESET = 16'h00C0;

	// port_width_select: seven select_narrow_bit fields
	localparam int NUM_NARROW = 7;
	localparam logic [6:0] PW_RESET = 7'h00;

	// timing register: wait_count_field per select, then strobe-length bits
	localparam int WS_W = 3;
	localparam int TM_DS_LSB = 24;
	localparam logic [31:0] TM_RESET = 32'h00DFFFFF;

	// status register fields
	localparam int ST_BOOT_NARROW = 0;
	localparam int ST_BOOT_PIN = 1;
	localparam int ST_BUSY = 2;

	// bus cycle counts in clocks
	localparam logic [3:0] CYC_BASE = 4'h3;
	localparam logic [3:0] CYC_MIN = 4'h4;
	localparam logic [3:0] CYC_WR_DS = 4'h4;
	localparam logic [2:0] WS_ACK = 3'h7;

	// transfer sizes
	localparam logic [1:0] SZ_BYTE = 2'h0;
	localparam logic [1:0] SZ_WORD = 2'h1;
	localparam logic [1:0] SZ_LONG = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_DONE = 2'b11
	} ebcs_state_t;

endpackage : ebcs_pkg

// ===== ebcs_sync.sv
/*
 * Two-stage synchroniser for a bundle of pin levels.
 * Assumes the inputs are asynchronous to clk; no reset, so a pin level is
 * already visible at the release of reset.
 */
`timescale 1ns/10ps
module ebcs_sync #(
	parameter int WIDTH = 1
) (
	// clock
	input wire logic clk,
	// levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk) begin
		meta_reg <= async_in;
		sync_out <= meta_reg;
	end

endmodule : ebcs_sync

// ===== ebcs_cycle_len.sv
/*
 * Clock count of one bus cycle from wait states, strobe length and the
 * fast-cycle choice. Assumes code 7 means waiting for the acknowledge.
 */
`timescale 1ns/10ps
module ebcs_cycle_len
	import ebcs_pkg::*;
(
	// cycle attributes
	input wire logic [2:0] wait_states,
	input wire logic fast,
	input wire logic write,
	input wire logic ds_length,
	// result
	output logic [3:0] cycle_len,
	output logic wait_ack
);
	logic [3:0] eff;
	logic [3:0] base;

	always_comb begin
		wait_ack = (wait_states == WS_ACK);
		eff = wait_ack ? 4'h0 : {1'b0, wait_states};
		base = CYC_BASE + eff;
		if (ds_length && write) begin
			cycle_len = CYC_WR_DS + eff;
		end else if (fast && !write) begin
			cycle_len = base;
		end else begin
			cycle_len = (base < CYC_MIN) ? CYC_MIN : base;
		end
	end

endmodule : ebcs_cycle_len

// ===== ebcs_sequencer.sv
/*
 * External bus cycle sequencer with dynamic port sizing, boot width latch
 * and the system control register, reached over APB.
 * Assumes a CPU-side request port on clk, pins synchronised here, and that
 * chip-select decoding happened upstream (the request names the select).
 */
// Functional notes
// - AS-length: fast read 3+ws, else max(4,3+ws)
// - DS-length: write 4+ws, read as
// - each select chooses 16- or 8-bit port
// - seven width bits, bit set means 8-bit
// - boot select width from pin latched at reset
// - select bit sequences transfer, high byte first
// - 8-bit transfers use data lines 7..0 only
// - boot width: pin 0 is 16, 1 is 8
// - system control register field layout
// - CPU reset sets divider bits 7,6 only
// - reset instruction clears all but idle bit
// - fast bit: reads three clocks, writes four
// - invert bit flips latched boot pin
// - wait code 0-6 waits, 7 waits acknowledge
`timescale 1ns/10ps
module ebcs_sequencer
	import ebcs_pkg::*;
#(
	parameter int ADDR_W = 24
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// cpu side
	input wire logic sw_reset,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [1:0] req_size,
	input wire logic [2:0] req_select,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [31:0] req_wdata,
	output logic resp_valid,
	output logic [31:0] resp_rdata,
	// external bus pins
	input wire logic boot_width_pin,
	input wire logic transfer_acknowledge_n,
	input wire logic [15:0] data_in,
	output logic [15:0] data_out,
	output logic data_oe,
	output logic [ADDR_W-1:0] bus_addr,
	output logic address_strobe_n,
	output logic data_strobe_n,
	output logic read_write_n,
	output logic [7:0] chip_select_line_n,
	// system control outputs
	output logic [15:0] system_control,
	output logic boot_narrow,
	output logic alt_port_free
);
	if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
		$error("ADDR_W must lie in 8..32");
	end

	logic [15:0] sc_reg;
	logic [6:0] pw_reg;
	logic [31:0] tm_reg;
	logic boot_pin_reg;
	logic latched_reg;
	logic [16:0] pin_sync;
	logic ack_low;
	logic [15:0] din_sync;
	logic pin_sync_boot;
	logic wr_en;
	logic rd_en;
	logic hit_sc;
	logic hit_pw;
	logic hit_tm;
	logic hit_st;
	logic [DEC_W-1:0] word_idx;
	logic [31:0] sc_wr;
	logic [31:0] pw_wr;
	logic [31:0] tm_wr;
	logic [31:0] rd_mux;

	ebcs_state_t state_reg;
	logic write_reg;
	logic narrow_reg;
	logic ds_len_reg;
	logic fast_reg;
	logic [2:0] ws_reg;
	logic [2:0] sel_reg;
	logic [1:0] pieces_reg;
	logic [1:0] piece_reg;
	logic [3:0] cnt_reg;
	logic [31:0] wdata_reg;
	logic [31:0] rdata_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [3:0] cyc_len;
	logic cyc_wait_ack;
	logic cyc_end;
	logic req_narrow;
	logic [1:0] req_pieces;
	logic [1:0] rem;
	logic [ADDR_W-1:0] piece_off;

	// pin synchronisers
	ebcs_sync #(
		.WIDTH(18)
	) u_pins (
		.clk(clk),
		.async_in({boot_width_pin, transfer_acknowledge_n, data_in}),
		.sync_out({pin_sync_boot, pin_sync})
	);
	assign ack_low = !pin_sync[16];
	assign din_sync = pin_sync[15:0];

	// boot width pin caught at the end of the reset sequence
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			latched_reg <= 1'b0;
		end else begin
			latched_reg <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst_n && !latched_reg) begin
			boot_pin_reg <= pin_sync_boot;
		end
	end

	assign boot_narrow = boot_pin_reg ^ sc_reg[SC_INV];
	assign alt_port_free = boot_narrow;
	assign system_control = sc_reg;

	// apb decode: zero-wait slave
	assign word_idx = paddr[DEC_W+1:2];
	assign hit_sc = (word_idx == SC_IDX[DEC_W-1:0]);
	assign hit_pw = (word_idx == PW_IDX[DEC_W-1:0]);
	assign hit_tm = (word_idx == TM_IDX[DEC_W-1:0]);
	assign hit_st = (word_idx == ST_IDX[DEC_W-1:0]);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !(hit_sc || hit_pw || hit_tm || hit_st);
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nv[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge

	assign sc_wr = merge({16'h0000, sc_reg}, pwdata, pstrb);
	assign pw_wr = merge({25'h0, pw_reg}, pwdata, pstrb);
	assign tm_wr = merge(tm_reg, pwdata, pstrb);

	// system control register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sc_reg <= SC_RESET;
		end else if (sw_reset) begin
			sc_reg <= sc_reg & (16'h0001 << SC_IDLE);
		end else if (wr_en && hit_sc) begin
			sc_reg <= sc_wr[15:0];
		end
	end

	// port width select register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pw_reg <= PW_RESET;
		end else if (wr_en && hit_pw) begin
			pw_reg <= pw_wr[NUM_NARROW-1:0];
		end
	end

	// wait counts and strobe lengths per select
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tm_reg <= TM_RESET;
		end else if (wr_en && hit_tm) begin
			tm_reg <= tm_wr;
		end
	end

	always_comb begin
		rd_mux = 32'h00000000;
		if (hit_sc) begin
			rd_mux = {16'h0000, sc_reg};
		end else if (hit_pw) begin
			rd_mux = {25'h0, pw_reg};
		end else if (hit_tm) begin
			rd_mux = tm_reg;
		end else if (hit_st) begin
			rd_mux[ST_BOOT_NARROW] = boot_narrow;
			rd_mux[ST_BOOT_PIN] = boot_pin_reg;
			rd_mux[ST_BUSY] = (state_reg != ST_IDLE);
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
		end else if (rd_en) begin
			prdata <= rd_mux;
		end
	end

	// port width of the requested select
	always_comb begin
		if (req_select == 3'h7) begin
			req_narrow = boot_narrow;
		end else begin
			req_narrow = pw_reg[req_select];
		end
		unique case (req_size)
			SZ_WORD: req_pieces = req_narrow ? 2'h1 : 2'h0;
			SZ_LONG: req_pieces = req_narrow ? 2'h3 : 2'h1;
			default: req_pieces = 2'h0;
		endcase
	end

	ebcs_cycle_len u_len (
		.wait_states(ws_reg),
		.fast(fast_reg),
		.write(write_reg),
		.ds_length(ds_len_reg),
		.cycle_len(cyc_len),
		.wait_ack(cyc_wait_ack)
	);

	assign cyc_end = (cnt_reg >= cyc_len) && (!cyc_wait_ack || ack_low);
	assign req_ready = (state_reg == ST_IDLE);
	assign rem = pieces_reg - piece_reg;

	// piece sequencing
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_reg <= ST_IDLE;
			piece_reg <= 2'h0;
			cnt_reg <= 4'h0;
		end else begin
			unique case (state_reg)
				ST_IDLE: begin
					if (req_valid) begin
						state_reg <= ST_RUN;
						piece_reg <= 2'h0;
						cnt_reg <= 4'h0;
					end
				end
				ST_RUN: begin
					if (!cyc_end) begin
						cnt_reg <= cnt_reg + 4'h1;
					end else if (piece_reg == pieces_reg) begin
						state_reg <= ST_DONE;
					end else begin
						piece_reg <= piece_reg + 2'h1;
						cnt_reg <= 4'h0;
					end
				end
				ST_DONE: state_reg <= ST_IDLE;
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// request capture
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			write_reg <= 1'b0;
			narrow_reg <= 1'b0;
			ds_len_reg <= 1'b0;
			fast_reg <= 1'b0;
			ws_reg <= 3'h0;
			sel_reg <= 3'h0;
			pieces_reg <= 2'h0;
			wdata_reg <= 32'h00000000;
			addr_reg <= '0;
		end else if (req_valid && req_ready) begin
			write_reg <= req_write;
			narrow_reg <= req_narrow || (req_size == SZ_BYTE);
			ds_len_reg <= tm_reg[TM_DS_LSB + req_select];
			fast_reg <= sc_reg[SC_FAST];
			ws_reg <= tm_reg[req_select*WS_W +: WS_W];
			sel_reg <= req_select;
			pieces_reg <= req_pieces;
			wdata_reg <= req_wdata;
			addr_reg <= req_addr;
		end
	end

	// read assembly, most significant piece first
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rdata_reg <= 32'h00000000;
		end else if (req_valid && req_ready) begin
			rdata_reg <= 32'h00000000;
		end else if (state_reg == ST_RUN && cyc_end && !write_reg) begin
			if (narrow_reg) begin
				rdata_reg <= {rdata_reg[23:0], din_sync[7:0]};
			end else begin
				rdata_reg <= {rdata_reg[15:0], din_sync};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			resp_valid <= 1'b0;
			resp_rdata <= 32'h00000000;
		end else begin
			resp_valid <= (state_reg == ST_DONE);
			if (state_reg == ST_DONE) begin
				resp_rdata <= rdata_reg;
			end
		end
	end

	// pin drive for the current piece
	assign piece_off = narrow_reg ? ADDR_W'(piece_reg) : ADDR_W'({piece_reg, 1'b0});

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bus_addr <= '0;
			data_out <= 16'h0000;
			data_oe <= 1'b0;
			address_strobe_n <= 1'b1;
			data_strobe_n <= 1'b1;
			read_write_n <= 1'b1;
			chip_select_line_n <= 8'hFF;
		end else if (state_reg == ST_RUN && !cyc_end) begin
			bus_addr <= addr_reg + piece_off;
			read_write_n <= !write_reg;
			data_oe <= write_reg;
			if (narrow_reg) begin
				data_out <= {8'h00, wdata_reg[rem*8 +: 8]};
			end else begin
				data_out <= wdata_reg[rem[0]*16 +: 16];
			end
			address_strobe_n <= 1'b0;
			data_strobe_n <= (cnt_reg == 4'h0);
			chip_select_line_n <= ~(8'h01 << sel_reg);
			if (ds_len_reg && cnt_reg == 4'h0) begin
				chip_select_line_n <= 8'hFF;
			end
		end else begin
			data_oe <= 1'b0;
			address_strobe_n <= 1'b1;
			data_strobe_n <= 1'b1;
			read_write_n <= 1'b1;
			chip_select_line_n <= 8'hFF;
		end
	end

endmodule : ebcs_sequencer

// ===== ebcs_sequencer_checker.sv
/* Port assertions for ebcs_sequencer.
   Sees only top ports; bound below. */
`timescale 1ns/10ps
module ebcs_checker
	import ebcs_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic pslverr,
	// cpu side
	input wire logic sw_reset,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic resp_valid,
	// bus and control
	input wire logic address_strobe_n,
	input wire logic data_strobe_n,
	input wire logic read_write_n,
	input wire logic [7:0] chip_select_line_n,
	input wire logic [15:0] system_control,
	input wire logic boot_narrow,
	input wire logic alt_port_free
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic [11:0] ix;
	logic mapped;
	assign ix = paddr[13:2];
	assign mapped = ix == SC_IDX[11:0] || ix == PW_IDX[11:0] || ix == TM_IDX[11:0] || ix == ST_IDX[11:0];
	sequence s_start(logic rd);
		$fell(address_strobe_n) && read_write_n == rd;
	endsequence
	a_unmapped_err: assert property (psel && penable && !mapped |-> pslverr)
		else $error("unmapped access gave no error");
	a_write_len: assert property (s_start(1'b0) |-> !address_strobe_n [*4])
		else $error("write cycle too short");
	a_read_len: assert property (s_start(1'b1) |-> !address_strobe_n [*3])
		else $error("read cycle too short");
	a_idle_kept: assert property (sw_reset |=> system_control == ($past(system_control) & 16'h0002))
		else $error("reset instruction result wrong");
	a_reset_value: assert property ($rose(rst_n) |-> system_control == SC_RESET)
		else $error("control reset value wrong");
	a_alt_port: assert property (alt_port_free == boot_narrow)
		else $error("port free differs from boot width");
	a_inv_flips: assert property ($changed(system_control[SC_INV]) |-> ##[0:1] $changed(boot_narrow))
		else $error("invert bit did not flip width");
	a_resp_gap: assert property (req_valid && req_ready |=> !resp_valid [*3])
		else $error("response too early");
	a_cs_onehot: assert property (!data_strobe_n |-> $onehot(~chip_select_line_n))
		else $error("select lines not one-hot");
endmodule : ebcs_checker

bind ebcs_sequencer ebcs_checker u_chk (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pslverr, .sw_reset,
	.req_valid, .req_ready, .resp_valid, .address_strobe_n, .data_strobe_n, .read_write_n, .chip_select_line_n,
	.system_control, .boot_narrow, .alt_port_free);

// ===== ebcs_mem_model.sv
/* Byte memory on the external bus.
   Bench gives lane mode and acknowledge delay. */
`timescale 1ns/10ps
module ebcs_mem_model (
	// clock
	input wire logic clk,
	// setup from bench
	input wire logic byte_lane,
	input wire logic [3:0] ack_dly,
	// bus
	input wire logic [23:0] bus_addr,
	input wire logic [7:0] chip_select_line_n,
	input wire logic read_write_n,
	input wire logic data_strobe_n,
	input wire logic data_oe,
	input wire logic [15:0] data_out,
	output logic [15:0] data_in,
	output logic transfer_acknowledge_n
);
	logic [7:0] mem [0:255];
	logic [15:0] pat = 16'hA5C3;
	logic [3:0] wcnt = 4'h0;
	logic [7:0] a;
	logic sel;
	initial transfer_acknowledge_n = 1'b1;
	assign a = bus_addr[7:0];
	assign sel = chip_select_line_n != 8'hFF;
	// idle bus and unused lanes toggle
	assign data_in = !(sel && read_write_n) ? pat : byte_lane ? {pat[15:8], mem[a]} : {mem[a], mem[a + 8'h01]};
	always @(posedge clk) begin
		pat <= ~pat;
		wcnt <= !sel ? 4'h0 : wcnt == 4'hF ? wcnt : wcnt + 4'h1;
		transfer_acknowledge_n <= !(sel && wcnt >= ack_dly);
		if (sel && data_oe && !data_strobe_n) begin
			if (byte_lane)
				mem[a] <= data_out[7:0];
			else begin
				mem[a] <= data_out[15:8];
				mem[a + 8'h01] <= data_out[7:0];
			end
		end
	end
endmodule : ebcs_mem_model

// ===== ebcs_sequencer_tb.sv
/* Self-checking bench for ebcs_sequencer.
   Assumes zero-wait APB and the request handshake. */
`timescale 1ns/10ps
module ebcs_sequencer_tb
	import ebcs_pkg::*;
;
	typedef struct packed {
		logic [2:0] sel;
		logic [1:0] sz;
		logic [2:0] ws;
		logic fast;
		logic ds;
		logic nar;
	} ebcs_case_t;
	ebcs_case_t cases [7] = '{
		'{3'h0, SZ_LONG, 3'h0, 1'b1, 1'b0, 1'b1},
		'{3'h1, SZ_WORD, 3'h2, 1'b0, 1'b1, 1'b1},
		'{3'h2, SZ_LONG, 3'h6, 1'b1, 1'b1, 1'b0},
		'{3'h3, SZ_BYTE, 3'h1, 1'b1, 1'b0, 1'b0},
		'{3'h7, SZ_WORD, 3'h3, 1'b0, 1'b0, 1'b1},
		'{3'h4, SZ_WORD, 3'h7, 1'b0, 1'b0, 1'b0},
		'{3'h5, SZ_BYTE, 3'h4, 1'b0, 1'b1, 1'b1}};
	logic clk, rst_n, psel, penable, pwrite, pready, pslverr, sw_reset, req_valid, req_ready, req_write;
	logic resp_valid, boot_width_pin, transfer_acknowledge_n, data_oe, address_strobe_n, data_strobe_n;
	logic read_write_n, boot_narrow, alt_port_free, byte_lane, err;
	logic [31:0] paddr, pwdata, prdata, req_wdata, resp_rdata, rd, wd, msk;
	logic [1:0] req_size;
	logic [2:0] req_select;
	logic [23:0] req_addr, bus_addr;
	logic [15:0] data_in, data_out, system_control;
	logic [7:0] chip_select_line_n;
	logic [3:0] ack_dly;
	ebcs_case_t c;
	int mismatches, cmp_count, as_cnt, last_len, pieces, p0, np, i, w;

	ebcs_sequencer dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready,
		.pslverr, .sw_reset, .req_valid, .req_ready, .req_write, .req_size, .req_select, .req_addr, .req_wdata,
		.resp_valid, .resp_rdata, .boot_width_pin, .transfer_acknowledge_n, .data_in, .data_out, .data_oe,
		.bus_addr, .address_strobe_n, .data_strobe_n, .read_write_n, .chip_select_line_n, .system_control,
		.boot_narrow, .alt_port_free);
	ebcs_mem_model mem (.clk, .byte_lane, .ack_dly, .bus_addr, .chip_select_line_n, .read_write_n,
		.data_strobe_n, .data_oe, .data_out, .data_in, .transfer_acknowledge_n);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// strobe length and piece count
	always @(posedge clk) begin
		if (!address_strobe_n)
			as_cnt <= as_cnt + 1;
		else if (as_cnt != 0) begin
			last_len <= as_cnt;
			pieces <= pieces + 1;
			as_cnt <= 0;
		end
	end

	task end_sim;
		$display("Checks %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task limit(input int n, input int lim);
		if (n >= lim) begin
			mismatches++;
			$display("Error at %0t: wait timed out", $time);
			end_sim();
		end
	endtask : limit

	task automatic apb(input logic wr, input logic [31:0] idx, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= idx << 2;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		limit(n, 20);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic xfer(input logic wr, input ebcs_case_t k, input logic [23:0] a, output logic [31:0] r);
		int n;
		req_valid <= 1'b1;
		req_write <= wr;
		req_size <= k.sz;
		req_select <= k.sel;
		req_addr <= a;
		req_wdata <= wd;
		p0 = pieces;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (req_ready !== 1'b1 && n < 50);
		limit(n, 50);
		req_valid <= 1'b0;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (resp_valid !== 1'b1 && n < 300);
		limit(n, 300);
		r = resp_rdata;
	endtask : xfer

	function automatic int elen(input logic wr, input ebcs_case_t k);
		int b;
		b = 3 + int'(k.ws);
		if (k.ds && wr)
			return b + 1;
		if (k.fast && !wr)
			return b;
		return b < 4 ? 4 : b;
	endfunction : elen

	initial begin
		{psel, penable, pwrite, sw_reset, req_valid, req_write, byte_lane, rst_n} = '0;
		{paddr, pwdata, req_wdata, req_addr, req_size, req_select} = '0;
		boot_width_pin = 1'b1;
		ack_dly = 4'h2;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(1'b0, SC_IDX, 32'h0, rd, err);
		chk(rd, 32'(SC_RESET));
		apb(1'b0, PW_IDX, 32'h0, rd, err);
		chk(rd, 32'h0);
		apb(1'b1, PW_IDX, 32'hFF, rd, err);
		apb(1'b0, PW_IDX, 32'h0, rd, err);
		chk(rd, 32'h7F);
		apb(1'b0, 32'hFFFFA9F0, 32'h0, rd, err);
		chk(32'(err), 32'h1);
		apb(1'b0, ST_IDX, 32'h0, rd, err);
		chk(32'(rd[1:0]), 32'h3);
		chk(32'({boot_narrow, alt_port_free}), 32'h3);
		for (i = 0; i < 7; i++) begin
			c = cases[i];
			byte_lane <= c.nar || c.sz == SZ_BYTE;
			apb(1'b1, PW_IDX, 32'(c.nar) << c.sel, rd, err);
			apb(1'b1, TM_IDX, (32'(c.ds) << (24 + c.sel)) | {8'h00, {8{c.ws}}}, rd, err);
			apb(1'b1, SC_IDX, 32'(c.fast) << SC_FAST, rd, err);
			wd = 32'h8E3F6A1D + 32'(i) * 32'h01010101;
			msk = c.sz == SZ_BYTE ? 32'hFF : c.sz == SZ_WORD ? 32'hFFFF : 32'hFFFFFFFF;
			np = c.sz == SZ_LONG ? (c.nar ? 4 : 2) : (c.sz == SZ_WORD && c.nar ? 2 : 1);
			for (w = 1; w >= 0; w--) begin
				xfer(1'(w), c, 24'(i * 16), rd);
				chk(32'(pieces - p0), 32'(np));
				if (c.ws != WS_ACK)
					chk(32'(last_len), 32'(elen(1'(w), c)));
			end
			chk(rd, wd & msk);
		end
		apb(1'b1, SC_IDX, 32'h2000, rd, err);
		apb(1'b0, ST_IDX, 32'h0, rd, err);
		chk(32'({rd[0], boot_narrow, alt_port_free}), 32'h0);
		apb(1'b1, SC_IDX, 32'hFFFF, rd, err);
		apb(1'b0, SC_IDX, 32'h0, rd, err);
		chk(rd, 32'hFFFF);
		sw_reset <= 1'b1;
		@(posedge clk);
		sw_reset <= 1'b0;
		apb(1'b0, SC_IDX, 32'h0, rd, err);
		chk(rd, 32'h0002);
		chk(32'(boot_narrow), 32'h1);
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		apb(1'b0, SC_IDX, 32'h0, rd, err);
		chk(rd, 32'(SC_RESET));
		end_sim();
	end
endmodule : ebcs_sequencer_tb
